/* design/pcoc_defines.svh */
// Offsets, field positions, reset values and masks of the panel/CRT output control.
// Assumes inclusion by bare name from the top-level design file.
`ifndef PCOC_DEFINES_SVH
`define PCOC_DEFINES_SVH

`define PCOC_CFG_OFS 8'h04
`define PCOC_CFG_RESET 32'h0000_0000
`define PCOC_CFG_WR_MASK 32'h03FF_FFEF

`define PCOC_B_PANEL_ON 27
`define PCOC_F_SEQ_DLY_HI 19
`define PCOC_F_SEQ_DLY_LO 17
`define PCOC_B_DITHER_EN 13
`define PCOC_B_FP_VS_POL 11
`define PCOC_B_FP_HS_POL 10
`define PCOC_B_CRT_VS_POL 9
`define PCOC_B_CRT_HS_POL 8
`define PCOC_B_PANEL_PIXEL_BUS_EN 7
`define PCOC_B_FP_PWR_EN 6
`define PCOC_B_DAC_PWR_N 5
`define PCOC_B_DAC_BLANK_EN 3
`define PCOC_B_CRT_VS_EN 2
`define PCOC_B_CRT_HS_EN 1
`define PCOC_B_DISP_EN 0

`define PCOC_STAGE_OFF 2'h0
`define PCOC_STAGE_VDD 2'h1
`define PCOC_STAGE_DATA 2'h2
`define PCOC_STAGE_FULL 2'h3

`endif

/* design/pcoc_pkg.sv */
// Types shared by the panel/CRT output control and its testbench.
// Assumes pcoc_defines.svh supplies the numeric constants.
package pcoc_pkg;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic blank;
    logic de;
  } pcoc_timing_t;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } pcoc_rgb_t;

  typedef enum logic {
    PCOC_DIR_DOWN,
    PCOC_DIR_UP
  } pcoc_dir_t;

endpackage : pcoc_pkg

/* design/pcoc_dither.sv */
// 24-bit to 18-bit ordered dither with a 2x2 pattern and frame alternation.
// Assumes pixel position parities come from the caller; output is registered.
module pcoc_dither (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Control
  input wire logic dither_en_i,
  input wire logic col_par_i,
  input wire logic row_par_i,
  input wire logic frame_par_i,
  // Pixel data
  input wire logic [23:0] pixel_i,
  output logic [17:0] pixel_o
);

  logic [1:0] thr;
  logic [17:0] pixel_next;

  // Pattern threshold, shifted on alternate frames
  assign thr = {col_par_i ^ row_par_i ^ frame_par_i, row_par_i};

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_chan
      logic [7:0] c;
      logic up;
      assign c = pixel_i[ch*8 +: 8];
      assign up = dither_en_i && (c[1:0] > thr) && (c[7:2] != 6'h3F);
      assign pixel_next[ch*6 +: 6] = c[7:2] + {5'h00, up};
    end
  endgenerate

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pixel_o <= 18'h0_0000;
    end else begin
      pixel_o <= pixel_next;
    end
  end

endmodule : pcoc_dither

/* design/pcoc_top.sv */
// Display output control: configuration register, sync polarity and enables,
// DAC power and blanking, panel power sequencer and panel data path.
// Assumes timing and pixel inputs synchronous to clk_sys_i, syncs active high.
`include "pcoc_defines.svh"

// Functional notes
// - Panel hsync polarity bit 10: 0 rests low pulsing high, 1 inverted.
// - CRT vsync polarity bit 9: 0 rests low pulsing high, 1 inverted.
// - CRT hsync polarity bit 8: 0 rests low pulsing high, 1 inverted.
// - Panel data enable bit 7 low forces all 18 pixel lines low.
// - Panel power bit 6 rising starts power-up, falling starts power-down.
// - DAC power bit 5 is active low; DACs down while it is 0.
// - DAC blank enable bit 3 low blanks DACs always, else normal blanking.
// - CRT vsync driven only while vsync enable bit 2 is 1.
// - CRT hsync driven only while hsync enable bit 1 is 1.
// - Display enable bit 0 low holds display control logic in reset.
// - Power-up order: supply, then data bus with syncs, then backlight.
// - Stages are separated by the frame count in the delay field, 8 frames when it is 0.
// - Power-down order: backlight, data bus, then supply, same delay.
// - Dithering approximates 24-bit pixels on the 18-bit panel.
// - Read-only panel-on bit changes only when a sequence completes.
// - Dither enable bit 13 turns dithering on when 1.
module pcoc_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  output logic [31:0] reg_rdata_o,
  // Graphics timing and pixels
  input wire pcoc_pkg::pcoc_timing_t timing_i,
  input wire pcoc_pkg::pcoc_rgb_t pixel_i,
  // Display control
  output logic display_reset_o,
  // CRT and DACs
  output logic crt_hsync_o,
  output logic crt_vsync_o,
  output logic dac_power_o,
  output logic dac_blank_o,
  output pcoc_pkg::pcoc_rgb_t dac_rgb_o,
  // Flat panel
  output logic panel_supply_enable_o,
  output logic panel_backlight_enable_o,
  output logic panel_display_enable_out_o,
  output logic panel_hsync_o,
  output logic panel_vsync_o,
  output logic [17:0] panel_pixel_bus_o
);

  logic [31:0] cfg_reg;
  logic pwr_prev_reg;
  logic [1:0] stage_reg;
  logic [1:0] stage_next;
  pcoc_pkg::pcoc_dir_t dir_reg;
  logic [2:0] frame_cnt_reg;
  logic panel_on_reg;
  logic vs_prev_reg;
  logic col_par_reg;
  logic row_par_reg;
  logic frame_par_reg;
  logic hs_prev_reg;
  pcoc_pkg::pcoc_timing_t t1_reg;
  pcoc_pkg::pcoc_rgb_t px1_reg;
  logic [17:0] dith_px;
  logic pipe_rst;
  logic pwr_edge;
  logic frame_evt;
  logic [1:0] target;
  logic [2:0] seq_dly;
  logic data_on;
  logic seq_step;

  assign pipe_rst = rst_i || !cfg_reg[`PCOC_B_DISP_EN];
  assign display_reset_o = !cfg_reg[`PCOC_B_DISP_EN];
  assign pwr_edge = cfg_reg[`PCOC_B_FP_PWR_EN] != pwr_prev_reg;
  assign frame_evt = timing_i.vsync && !vs_prev_reg;
  assign seq_dly = cfg_reg[`PCOC_F_SEQ_DLY_HI:`PCOC_F_SEQ_DLY_LO];
  assign target = (dir_reg == pcoc_pkg::PCOC_DIR_UP) ? `PCOC_STAGE_FULL : `PCOC_STAGE_OFF;
  assign data_on = stage_reg >= `PCOC_STAGE_DATA;
  assign seq_step = frame_evt && (stage_reg != target) && ((frame_cnt_reg + 3'h1) == seq_dly);

  // Configuration register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cfg_reg <= `PCOC_CFG_RESET;
    end else if (reg_wr_i && reg_addr_i == `PCOC_CFG_OFS) begin
      cfg_reg <= reg_wdata_i & `PCOC_CFG_WR_MASK;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      if (reg_addr_i == `PCOC_CFG_OFS) begin
        reg_rdata_o <= cfg_reg | ({31'h0000_0000, panel_on_reg} << `PCOC_B_PANEL_ON);
      end else begin
        reg_rdata_o <= 32'h0000_0000;
      end
    end
  end

  // Power sequencer: edge moves one stage at once, later stages wait frames
  always_comb begin
    stage_next = stage_reg;
    if (pwr_edge) begin
      if (cfg_reg[`PCOC_B_FP_PWR_EN] && stage_reg != `PCOC_STAGE_FULL) begin
        stage_next = stage_reg + 2'h1;
      end else if (!cfg_reg[`PCOC_B_FP_PWR_EN] && stage_reg != `PCOC_STAGE_OFF) begin
        stage_next = stage_reg - 2'h1;
      end
    end else if (seq_step) begin
      if (dir_reg == pcoc_pkg::PCOC_DIR_UP) begin
        stage_next = stage_reg + 2'h1;
      end else begin
        stage_next = stage_reg - 2'h1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stage_reg <= `PCOC_STAGE_OFF;
      dir_reg <= pcoc_pkg::PCOC_DIR_DOWN;
      pwr_prev_reg <= 1'b0;
      vs_prev_reg <= 1'b0;
    end else begin
      stage_reg <= stage_next;
      pwr_prev_reg <= cfg_reg[`PCOC_B_FP_PWR_EN];
      vs_prev_reg <= timing_i.vsync;
      if (pwr_edge) begin
        dir_reg <= cfg_reg[`PCOC_B_FP_PWR_EN] ? pcoc_pkg::PCOC_DIR_UP : pcoc_pkg::PCOC_DIR_DOWN;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i || pwr_edge || seq_step) begin
      frame_cnt_reg <= 3'h0;
    end else if (frame_evt && stage_reg != target) begin
      frame_cnt_reg <= frame_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      panel_on_reg <= 1'b0;
    end else if (stage_next == `PCOC_STAGE_FULL) begin
      panel_on_reg <= 1'b1;
    end else if (stage_next == `PCOC_STAGE_OFF) begin
      panel_on_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      panel_supply_enable_o <= 1'b0;
      panel_backlight_enable_o <= 1'b0;
    end else begin
      panel_supply_enable_o <= stage_next != `PCOC_STAGE_OFF;
      panel_backlight_enable_o <= stage_next == `PCOC_STAGE_FULL;
    end
  end

  // Pixel position parities for the dither pattern
  always_ff @(posedge clk_sys_i) begin
    if (pipe_rst) begin
      col_par_reg <= 1'b0;
      row_par_reg <= 1'b0;
      frame_par_reg <= 1'b0;
      hs_prev_reg <= 1'b0;
    end else begin
      hs_prev_reg <= timing_i.hsync;
      col_par_reg <= timing_i.de ? !col_par_reg : 1'b0;
      if (frame_evt) begin
        row_par_reg <= 1'b0;
        frame_par_reg <= !frame_par_reg;
      end else if (timing_i.hsync && !hs_prev_reg) begin
        row_par_reg <= !row_par_reg;
      end
    end
  end

  pcoc_dither u_dither (
    .clk_sys_i(clk_sys_i),
    .rst_i(pipe_rst),
    .dither_en_i(cfg_reg[`PCOC_B_DITHER_EN]),
    .col_par_i(col_par_reg),
    .row_par_i(row_par_reg),
    .frame_par_i(frame_par_reg),
    .pixel_i(pixel_i),
    .pixel_o(dith_px)
  );

  // First pipeline stage, aligned with the dither output
  always_ff @(posedge clk_sys_i) begin
    if (pipe_rst) begin
      t1_reg <= '{hsync: 1'b0, vsync: 1'b0, blank: 1'b1, de: 1'b0};
      px1_reg <= '{r: 8'h00, g: 8'h00, b: 8'h00};
    end else begin
      t1_reg <= timing_i;
      px1_reg <= pixel_i;
    end
  end

  // CRT and DAC outputs; a disabled sync is held low
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      crt_hsync_o <= 1'b0;
      crt_vsync_o <= 1'b0;
      dac_blank_o <= 1'b1;
      dac_rgb_o <= '{r: 8'h00, g: 8'h00, b: 8'h00};
    end else begin
      crt_hsync_o <= cfg_reg[`PCOC_B_CRT_HS_EN] &&
                     (t1_reg.hsync ^ cfg_reg[`PCOC_B_CRT_HS_POL]);
      crt_vsync_o <= cfg_reg[`PCOC_B_CRT_VS_EN] &&
                     (t1_reg.vsync ^ cfg_reg[`PCOC_B_CRT_VS_POL]);
      dac_blank_o <= !cfg_reg[`PCOC_B_DAC_BLANK_EN] || t1_reg.blank;
      dac_rgb_o <= px1_reg;
    end
  end

  assign dac_power_o = cfg_reg[`PCOC_B_DAC_PWR_N];

  // Panel outputs follow the sequencer's data stage
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      panel_hsync_o <= 1'b0;
      panel_vsync_o <= 1'b0;
      panel_display_enable_out_o <= 1'b0;
      panel_pixel_bus_o <= 18'h0_0000;
    end else begin
      panel_hsync_o <= data_on && (t1_reg.hsync ^ cfg_reg[`PCOC_B_FP_HS_POL]);
      panel_vsync_o <= data_on && (t1_reg.vsync ^ cfg_reg[`PCOC_B_FP_VS_POL]);
      panel_display_enable_out_o <= data_on && t1_reg.de;
      panel_pixel_bus_o <= (data_on && cfg_reg[`PCOC_B_PANEL_PIXEL_BUS_EN]) ? dith_px : 18'h0_0000;
    end
  end

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  chk_panel_hs_pol: assert property (data_on |=>
    panel_hsync_o == ($past(t1_reg.hsync) ^ $past(cfg_reg[`PCOC_B_FP_HS_POL])))
    else $error("panel hsync level wrong for polarity");
  chk_crt_vs_pol: assert property (cfg_reg[`PCOC_B_CRT_VS_EN] |=>
    crt_vsync_o == ($past(t1_reg.vsync) ^ $past(cfg_reg[`PCOC_B_CRT_VS_POL])))
    else $error("crt vsync level wrong for polarity");
  chk_crt_hs_pol: assert property (cfg_reg[`PCOC_B_CRT_HS_EN] |=>
    crt_hsync_o == ($past(t1_reg.hsync) ^ $past(cfg_reg[`PCOC_B_CRT_HS_POL])))
    else $error("crt hsync level wrong for polarity");
  chk_panel_data_low: assert property (!cfg_reg[`PCOC_B_PANEL_PIXEL_BUS_EN] |=>
    panel_pixel_bus_o == 18'h0_0000)
    else $error("panel pixel bus not forced low");
  chk_pwr_up_start: assert property ($rose(cfg_reg[`PCOC_B_FP_PWR_EN]) &&
    stage_reg == `PCOC_STAGE_OFF |=> ##1 panel_supply_enable_o)
    else $error("power-up did not raise supply");
  chk_dac_pwr_down: assert property (!cfg_reg[`PCOC_B_DAC_PWR_N] |-> !dac_power_o)
    else $error("dacs powered while bit clear");
  chk_dac_blank_on: assert property (!cfg_reg[`PCOC_B_DAC_BLANK_EN] |=> dac_blank_o)
    else $error("dacs not blanked");
  chk_crt_vs_off: assert property (!cfg_reg[`PCOC_B_CRT_VS_EN] [*2] |-> !crt_vsync_o)
    else $error("crt vsync driven while disabled");
  chk_crt_hs_off: assert property (!cfg_reg[`PCOC_B_CRT_HS_EN] [*2] |-> !crt_hsync_o)
    else $error("crt hsync driven while disabled");
  chk_disp_reset: assert property (!cfg_reg[`PCOC_B_DISP_EN] [*3] |->
    !panel_display_enable_out_o && panel_pixel_bus_o == 18'h0_0000)
    else $error("panel data active while display in reset");
  chk_up_order: assert property ($rose(panel_backlight_enable_o) |->
    panel_supply_enable_o && $past(data_on))
    else $error("backlight raised before data and supply");
  chk_step_frames: assert property (($changed(stage_reg) && !$past(pwr_edge)) |->
    $past(frame_evt) && ($past(frame_cnt_reg) + 3'h1) == $past(seq_dly))
    else $error("stage step without full frame delay");
  chk_down_order: assert property ($fell(panel_supply_enable_o) |->
    !panel_backlight_enable_o && !$past(data_on))
    else $error("supply dropped before data and backlight");
  chk_panel_on: assert property ($changed(panel_on_reg) |->
    stage_reg == `PCOC_STAGE_FULL || stage_reg == `PCOC_STAGE_OFF)
    else $error("panel-on moved mid-sequence");

endmodule : pcoc_top

/* tb/pcoc_panel_model.sv */
// Flat panel stand-in that latches an error when data enable or backlight is high without supply.
// Assumes the block's panel outputs are sampled on the system clock.
module pcoc_panel_model (
  // Clock
  input wire logic clk_sys_i,
  // Panel pins
  input wire logic supply_i,
  input wire logic backlight_i,
  input wire logic de_i,
  // Status
  output logic order_err_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic err_seen = 1'b0;
  assign order_err_o = err_seen;
  // An unpowered panel must never see data or light
  always @(posedge clk_sys_i) begin
    if ((de_i || backlight_i) && !supply_i) begin
      err_seen <= 1'b1;
    end
  end
endmodule : pcoc_panel_model

/* tb/tb_panel_crt_output_control.sv */
// Bench for the panel/CRT output control: register access, sync scans, power sequence.
// Assumes the design files and the panel model are compiled first.
module tb_panel_crt_output_control;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic [31:0] reg_rdata_o;
  logic [31:0] cfg;
  pcoc_pkg::pcoc_timing_t timing_i = '0;
  pcoc_pkg::pcoc_timing_t t1 = '0;
  pcoc_pkg::pcoc_timing_t t2 = '0;
  pcoc_pkg::pcoc_rgb_t pixel_i = 24'hA5_3CF0;
  pcoc_pkg::pcoc_rgb_t dac_rgb;
  logic disp_rst, crt_hs, crt_vs, dac_pwr, dac_blank, pst, pbk, pde, phs, pvs, order_err;
  logic [17:0] pbus;
  logic [2:0] ps;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int pos = 0;

  assign ps = {pbk, pde, pst};

  pcoc_top dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .timing_i(timing_i), .pixel_i(pixel_i), .display_reset_o(disp_rst),
    .crt_hsync_o(crt_hs), .crt_vsync_o(crt_vs), .dac_power_o(dac_pwr),
    .dac_blank_o(dac_blank), .dac_rgb_o(dac_rgb), .panel_supply_enable_o(pst),
    .panel_backlight_enable_o(pbk), .panel_display_enable_out_o(pde),
    .panel_hsync_o(phs), .panel_vsync_o(pvs), .panel_pixel_bus_o(pbus)
  );

  pcoc_panel_model panel (
    .clk_sys_i(clk_sys_i), .supply_i(pst), .backlight_i(pbk), .de_i(pde),
    .order_err_o(order_err)
  );

  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic complete_run;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run

  // Frame of 4 lines by 8 pixels; two tb stages mirror the block's 2-cycle path
  always @(posedge clk_sys_i) begin
    pos <= (pos + 1) % 32;
    timing_i.hsync <= (pos % 8) == 0;
    timing_i.vsync <= pos < 8;
    timing_i.de <= (pos % 8) > 1 && pos >= 8;
    timing_i.blank <= !((pos % 8) > 1 && pos >= 8);
    t1 <= timing_i;
    t2 <= t1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    check("rdata", reg_rdata_o, exp);
  endtask : rd

  task automatic scan(input logic [31:0] c, input logic full);
    int ups;
    ups = 0;
    wr(8'h04, c);
    repeat (40) @(posedge clk_sys_i);
    repeat (32) begin
      @(negedge clk_sys_i);
      check("crt_hs", crt_hs, c[1] & (t2.hsync ^ c[8]));
      check("crt_vs", crt_vs, c[2] & (t2.vsync ^ c[9]));
      check("blank", dac_blank, !c[3] | t2.blank);
      check("dac_pwr", dac_pwr, c[5]);
      check("disp_rst", disp_rst, 1'b0);
      check("dac_rgb", dac_rgb, pixel_i);
      if (full) begin
        check("p_hs", phs, t2.hsync ^ c[10]);
        check("p_vs", pvs, t2.vsync ^ c[11]);
        check("p_de", pde, t2.de);
        if (c[7] && c[13]) begin
          // Dithered red may round up by one step; green and blue have no remainder
          if (pbus[17:12] == 6'h2A) begin
            ups = ups + 1;
          end
          check("pbus_gb", pbus[11:0], {6'h0F, 6'h3C});
          check("pbus_r", pbus[17:12] == 6'h29 || pbus[17:12] == 6'h2A, 1'b1);
        end else if (!c[7] || t2.de) begin
          check("pbus", pbus, c[7] ? {6'h29, 6'h0F, 6'h3C} : 18'h0_0000);
        end
      end
    end
    if (full && c[7] && c[13]) begin
      check("dither_mix", ups > 0 && ups < 32, 1'b1);
    end
  endtask : scan

  // Counts frame starts until panel pin sel reaches lvl
  task automatic frames_until(input int sel, input logic lvl, input int exp);
    int n;
    int k;
    n = 0;
    k = 0;
    while (ps[sel] !== lvl && k < 1000) begin
      @(negedge clk_sys_i);
      k = k + 1;
      if (ps[sel] !== lvl && timing_i.vsync && !t1.vsync) begin
        n = n + 1;
      end
    end
    check("frames", n, exp);
  endtask : frames_until

  initial begin
    repeat (3) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(negedge clk_sys_i);
    check("disp_rst", disp_rst, 1'b1);
    rd(8'h04, 32'h0000_0000);
    rd(8'h08, 32'h0000_0000);
    wr(8'h04, 32'hFFFF_FFBF);
    rd(8'h04, 32'h03FF_FFAF);
    wr(8'h08, 32'h0000_0000);
    rd(8'h04, 32'h03FF_FFAF);
    for (int i = 0; i < 16; i++) begin
      cfg = 32'h0000_0001;
      cfg[1] = i[0];
      cfg[2] = i[1];
      cfg[8] = i[2];
      cfg[9] = i[3];
      cfg[3] = i[2] ^ i[0];
      cfg[5] = i[1];
      scan(cfg, 1'b0);
    end
    cfg = 32'h0004_00EF;
    wr(8'h04, cfg);
    repeat (3) @(negedge clk_sys_i);
    check("up", ps, 3'b001);
    frames_until(2, 1'b1, 4);
    rd(8'h04, cfg | 32'h0800_0000);
    scan(cfg, 1'b1);
    cfg = 32'h0004_046F;
    scan(cfg, 1'b1);
    cfg = 32'h0004_2CEF;
    scan(cfg, 1'b1);
    // Display reset while the panel is fully up silences the panel data path
    wr(8'h04, cfg & 32'hFFFF_FFFE);
    repeat (3) @(negedge clk_sys_i);
    check("disp_rst_on", disp_rst, 1'b1);
    check("pbus_rst", pbus, 18'h0_0000);
    check("pde_rst", pde, 1'b0);
    wr(8'h04, cfg);
    wr(8'h04, cfg & 32'hFFFF_FFBF);
    repeat (3) @(negedge clk_sys_i);
    check("bkl_off", pbk, 1'b0);
    frames_until(0, 1'b0, 4);
    rd(8'h04, cfg & 32'hFFFF_FFBF);
    wr(8'h04, cfg);
    repeat (3) @(negedge clk_sys_i);
    wr(8'h04, cfg & 32'hFFFF_FFBF);
    repeat (3) @(negedge clk_sys_i);
    check("reverse", ps, 3'b000);
    check("order", order_err, 1'b0);
    complete_run();
  end
endmodule : tb_panel_crt_output_control
